// [tws_pkg.sv]
// Shared constants and types for the high-speed mode entry and exit logic
package tws_pkg;

    // System clock rate and bus lockup timeout
    localparam int TWS_CLK_HZ = 40_000_000;
    localparam int TWS_TIMEOUT_MS = 28;
    localparam int TWS_TIMEOUT_CYC = TWS_TIMEOUT_MS * (TWS_CLK_HZ / 1000);

    // Link sampling clock period and spike filter widths
    localparam int TWS_LINK_PERIOD_PS = 15000;
    localparam int TWS_FS_SPIKE_NS = 50;
    localparam int TWS_HS_SPIKE_NS = 10;
    localparam int TWS_FS_FILT_RAW =
        (TWS_FS_SPIKE_NS * 1000 + TWS_LINK_PERIOD_PS - 1) / TWS_LINK_PERIOD_PS;
    localparam int TWS_HS_FILT_RAW =
        (TWS_HS_SPIKE_NS * 1000 + TWS_LINK_PERIOD_PS - 1) / TWS_LINK_PERIOD_PS;
    localparam int TWS_FS_FILT_CYC = (TWS_FS_FILT_RAW < 1) ? 1 : TWS_FS_FILT_RAW;
    localparam int TWS_HS_FILT_CYC = (TWS_HS_FILT_RAW < 1) ? 1 : TWS_HS_FILT_RAW;
    localparam int TWS_FILT_W = 3;

    // Byte framing
    localparam logic [3:0] TWS_BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] TWS_MC_PATTERN = 5'h01;
    localparam logic [6:0] TWS_SLAVE_ADDR_DFLT = 7'h40;

    // Reset values
    localparam logic TWS_HS_RESET = 1'b0;
    localparam logic [7:0] TWS_SHIFT_RESET = 8'h00;

    typedef enum logic [1:0]
    {
        TWS_ST_IDLE,
        TWS_ST_SHIFT,
        TWS_ST_ACK,
        TWS_ST_SKIP
    } tws_state_e;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } tws_bus_s;

    // Upper five bits select the master code; low three are don't-care
    function automatic logic tws_is_mc(input logic [7:0] byte_val);
        return byte_val[7:3] == TWS_MC_PATTERN;
    endfunction

endpackage

// [tws_spike_filter.sv]
// Spike suppression filter for the two bus lines with selectable width
`timescale 1ns/1ps
module tws_spike_filter import tws_pkg::*;
#(
    parameter int CNT_W = TWS_FILT_W
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Synchronised line levels and filter width
    input wire tws_bus_s sample_in,
    input wire logic [CNT_W-1:0] limit_in,
    // Filtered line levels
    output tws_bus_s filt_out
);

    logic [1:0] raw;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;
    logic [CNT_W-1:0] cnt_reg [2];
    logic [CNT_W-1:0] cnt_next [2];

    assign raw = {sample_in.scl, sample_in.sda};

    // A change must persist for limit_in samples before it is passed on
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            lvl_next[i] = lvl_reg[i];
            cnt_next[i] = '0;
            if (raw[i] != lvl_reg[i])
            begin
                if (cnt_reg[i] + CNT_W'(1) >= limit_in)
                begin
                    lvl_next[i] = raw[i];
                end
                else
                begin
                    cnt_next[i] = cnt_reg[i] + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lvl_reg <= 2'h3;
            cnt_reg[0] <= '0;
            cnt_reg[1] <= '0;
        end
        else
        begin
            lvl_reg <= lvl_next;
            cnt_reg[0] <= cnt_next[0];
            cnt_reg[1] <= cnt_next[1];
        end
    end

    assign filt_out.scl = lvl_reg[1];
    assign filt_out.sda = lvl_reg[0];

endmodule // tws_spike_filter

// [tws_hs_mode_switch.sv]
// High-speed mode entry and exit logic of the two-wire slave interface
`timescale 1ns/1ps
module tws_hs_mode_switch import tws_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TWS_TIMEOUT_CYC,
    parameter logic [6:0] SLAVE_ADDR = TWS_SLAVE_ADDR_DFLT
)
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link sampling clock
    input wire logic link_clk_in,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Status in the system domain
    output logic high_speed_mode_out,
    output logic timeout_out
);

    localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);

    // Link domain reset, released on the link clock
    logic lrst_meta_reg;
    logic lrst_reg;

    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lrst_meta_reg <= 1'b1;
            lrst_reg <= 1'b1;
        end
        else
        begin
            lrst_meta_reg <= 1'b0;
            lrst_reg <= lrst_meta_reg;
        end
    end

    // Link domain state
    tws_bus_s pin_meta_reg;
    tws_bus_s pin_sync_reg;
    tws_bus_s filt;
    tws_bus_s prev_reg;
    logic abt_meta_reg;
    logic abt_sync_reg;
    logic abt_prev_reg;
    tws_state_e state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic first_reg, first_next;
    logic addressed_reg, addressed_next;
    logic mc_slot_reg, mc_slot_next;
    logic hs_reg, hs_next;
    logic oe_reg, oe_next;
    logic act_reg, act_next;
    logic busy_reg, busy_next;
    logic sda_drv_reg;
    logic abort_tgl_reg;
    logic [TWS_FILT_W-1:0] filt_limit;
    logic start_det, stop_det, scl_rise, scl_fall, abort_evt, quiet, decide;

    // High-speed filtering is a narrower spike window
    assign filt_limit = hs_reg ? TWS_FILT_W'(TWS_HS_FILT_CYC)
        : TWS_FILT_W'(TWS_FS_FILT_CYC);

    tws_spike_filter #(
        .CNT_W(TWS_FILT_W)
    ) u_filter (
        .clk_in(link_clk_in),
        .rst_in(lrst_reg),
        .sample_in(pin_sync_reg),
        .limit_in(filt_limit),
        .filt_out(filt)
    );

    assign start_det = prev_reg.scl & filt.scl & prev_reg.sda & ~filt.sda;
    assign stop_det = prev_reg.scl & filt.scl & ~prev_reg.sda & filt.sda;
    assign scl_rise = ~prev_reg.scl & filt.scl;
    assign scl_fall = prev_reg.scl & ~filt.scl;
    assign abort_evt = abt_sync_reg ^ abt_prev_reg;
    assign quiet = ~abort_evt & ~stop_det & ~start_det;
    assign decide = quiet & (state_reg == TWS_ST_SHIFT) & scl_fall
        & (bit_reg == TWS_BITS_PER_BYTE);

    always_comb
    begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        first_next = first_reg;
        addressed_next = addressed_reg;
        mc_slot_next = mc_slot_reg;
        hs_next = hs_reg;
        oe_next = oe_reg;
        act_next = act_reg;
        // Clock activity feeds the lockup timer
        if (scl_rise && state_reg != TWS_ST_IDLE)
        begin
            act_next = ~act_reg;
        end
        if (abort_evt)
        begin
            state_next = TWS_ST_IDLE;
            hs_next = TWS_HS_RESET;
            oe_next = 1'b0;
        end
        else if (stop_det)
        begin
            state_next = TWS_ST_IDLE;
            hs_next = TWS_HS_RESET;
            oe_next = 1'b0;
        end
        else if (start_det)
        begin
            // Repeated start keeps the mode; framing restarts
            state_next = TWS_ST_SHIFT;
            bit_next = '0;
            first_next = 1'b1;
            addressed_next = 1'b0;
            mc_slot_next = 1'b0;
            oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                TWS_ST_SHIFT:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], filt.sda};
                        bit_next = bit_reg + 4'h1;
                    end
                    if (decide)
                    begin
                        state_next = TWS_ST_ACK;
                        first_next = 1'b0;
                        if (first_reg && tws_is_mc(shift_reg))
                        begin
                            hs_next = 1'b1;
                            mc_slot_next = 1'b1;
                            addressed_next = 1'b0;
                            oe_next = 1'b0;
                        end
                        else if (first_reg)
                        begin
                            // Write requests to our address are acknowledged
                            addressed_next = (shift_reg[7:1] == SLAVE_ADDR)
                                & ~shift_reg[0];
                            oe_next = (shift_reg[7:1] == SLAVE_ADDR) & ~shift_reg[0];
                        end
                        else
                        begin
                            oe_next = addressed_reg;
                        end
                    end
                end
                TWS_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_next = 1'b0;
                        bit_next = '0;
                        mc_slot_next = 1'b0;
                        state_next = addressed_reg ? TWS_ST_SHIFT : TWS_ST_SKIP;
                    end
                end
                TWS_ST_SKIP:
                begin
                    oe_next = 1'b0;
                end
                TWS_ST_IDLE:
                begin
                    oe_next = 1'b0;
                end
                default:
                begin
                    state_next = TWS_ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
        // Registered so the crossing never sees a decode glitch
        busy_next = (state_next != TWS_ST_IDLE);
    end

    always_ff @(posedge link_clk_in or posedge lrst_reg)
    begin
        if (lrst_reg)
        begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
            prev_reg <= '1;
            abt_meta_reg <= 1'b0;
            abt_sync_reg <= 1'b0;
            abt_prev_reg <= 1'b0;
            state_reg <= TWS_ST_IDLE;
            bit_reg <= '0;
            shift_reg <= TWS_SHIFT_RESET;
            first_reg <= 1'b0;
            addressed_reg <= 1'b0;
            mc_slot_reg <= 1'b0;
            hs_reg <= TWS_HS_RESET;
            oe_reg <= 1'b0;
            act_reg <= 1'b0;
            busy_reg <= 1'b0;
            sda_drv_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= '{scl: scl_in, sda: sda_in};
            pin_sync_reg <= pin_meta_reg;
            prev_reg <= filt;
            abt_meta_reg <= abort_tgl_reg;
            abt_sync_reg <= abt_meta_reg;
            abt_prev_reg <= abt_sync_reg;
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            first_reg <= first_next;
            addressed_reg <= addressed_next;
            mc_slot_reg <= mc_slot_next;
            hs_reg <= hs_next;
            oe_reg <= oe_next;
            act_reg <= act_next;
            busy_reg <= busy_next;
            sda_drv_reg <= 1'b0;
        end
    end

    // Open drain: only ever drives low
    assign sda_out = sda_drv_reg;
    assign sda_oe_out = oe_reg;

    // System domain: lockup timer and status
    logic busy_meta_reg, busy_sync_reg;
    logic act_meta_reg, act_sync_reg, act_prev_reg;
    logic hs_meta_reg, hs_sync_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic timeout_reg, timeout_next;
    logic abort_tgl_next;
    logic activity;

    assign activity = act_sync_reg ^ act_prev_reg;

    // Timer restarts on every rising SCL edge, so only a truly stalled bus trips it
    always_comb
    begin
        cnt_next = cnt_reg;
        timeout_next = 1'b0;
        abort_tgl_next = abort_tgl_reg;
        if (!busy_sync_reg || activity)
        begin
            cnt_next = '0;
        end
        else if (cnt_reg == CNT_W'(TIMEOUT_CYCLES - 1))
        begin
            cnt_next = '0;
            timeout_next = 1'b1;
            abort_tgl_next = ~abort_tgl_reg;
        end
        else
        begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_meta_reg <= 1'b0;
            busy_sync_reg <= 1'b0;
            act_meta_reg <= 1'b0;
            act_sync_reg <= 1'b0;
            act_prev_reg <= 1'b0;
            hs_meta_reg <= TWS_HS_RESET;
            hs_sync_reg <= TWS_HS_RESET;
            cnt_reg <= '0;
            timeout_reg <= 1'b0;
            abort_tgl_reg <= 1'b0;
        end
        else
        begin
            busy_meta_reg <= busy_reg;
            busy_sync_reg <= busy_meta_reg;
            act_meta_reg <= act_reg;
            act_sync_reg <= act_meta_reg;
            act_prev_reg <= act_sync_reg;
            hs_meta_reg <= hs_reg;
            hs_sync_reg <= hs_meta_reg;
            cnt_reg <= cnt_next;
            timeout_reg <= timeout_next;
            abort_tgl_reg <= abort_tgl_next;
        end
    end

    assign high_speed_mode_out = hs_sync_reg;
    assign timeout_out = timeout_reg;

    a_mc_nack_slot: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        (decide && first_reg && tws_is_mc(shift_reg)) |=> !oe_reg && mc_slot_reg
            ##1 (!oe_reg throughout (state_reg == TWS_ST_ACK)[*1]))
        else $error("SDA driven in master code acknowledge slot");

    a_mc_enter_hs: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        $rose(hs_reg) |-> $past(decide) && $past(first_reg) && tws_is_mc($past(shift_reg)))
        else $error("High-speed mode entered without a master code");

    a_mc_not_addr: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        (decide && first_reg && tws_is_mc(shift_reg)) |=> !addressed_reg)
        else $error("Master code taken as slave address");

    a_addr_ack: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        (decide && first_reg && !tws_is_mc(shift_reg) && shift_reg[7:1] == SLAVE_ADDR
            && !shift_reg[0]) |=> oe_reg && state_reg == TWS_ST_ACK)
        else $error("Own address not acknowledged");

    a_start_frame: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        (start_det && !abort_evt) |=> state_reg == TWS_ST_SHIFT && bit_reg == 4'h0 && first_reg)
        else $error("Start condition did not restart framing");

    a_stop_idle: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        stop_det |=> state_reg == TWS_ST_IDLE && !oe_reg)
        else $error("Stop condition did not end the transfer");

    a_stop_exit_hs: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        (hs_reg && stop_det) |=> !hs_reg)
        else $error("High-speed mode kept after stop");

    a_abort_clear: assert property (@(posedge link_clk_in) disable iff (lrst_reg)
        abort_evt |=> state_reg == TWS_ST_IDLE && !oe_reg && !hs_reg)
        else $error("Timeout did not release the bus");

    a_timeout_fire: assert property (@(posedge clk_in) disable iff (rst_in)
        (busy_sync_reg && !activity && cnt_reg == CNT_W'(TIMEOUT_CYCLES - 1))
            |=> timeout_reg && (abort_tgl_reg != $past(abort_tgl_reg)))
        else $error("Timeout not raised at the count limit");

    a_timeout_fs: assert property (@(posedge clk_in) disable iff (rst_in)
        timeout_reg |-> ##[1:12] !high_speed_mode_out)
        else $error("Normal mode not restored after timeout");

endmodule // tws_hs_mode_switch

// [tws_master_model.sv]
// Bus master model driving both lines as open-drain pulls
`timescale 1ns/1ps
module tws_master_model import tws_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Resolved data wire
    input wire logic sda_in,
    // Pull requests, high pulls the line low
    output logic scl_low_out,
    output logic sda_low_out
);
    int t_low = 52;
    int t_high = 24;

    initial
    begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Code byte always at normal rate; only later transfers go fast
    task automatic set_speed(input logic fast);
        t_low = fast ? 8 : 52;
        t_high = fast ? 4 : 24;
    endtask

    // Entered with both lines released
    task automatic start_cond();
        wait_cyc(1);
        sda_low_out <= 1'b1;
        wait_cyc(t_high);
        scl_low_out <= 1'b1;
    endtask

    // Entered with SCL low
    task automatic restart();
        wait_cyc(t_low / 2);
        sda_low_out <= 1'b0;
        wait_cyc(t_low / 2);
        scl_low_out <= 1'b0;
        wait_cyc(t_high);
        sda_low_out <= 1'b1;
        wait_cyc(t_high);
        scl_low_out <= 1'b1;
    endtask

    task automatic stop_cond();
        wait_cyc(t_low / 2);
        sda_low_out <= 1'b1;
        wait_cyc(t_low / 2);
        scl_low_out <= 1'b0;
        wait_cyc(t_high);
        sda_low_out <= 1'b0;
        wait_cyc(t_high);
    endtask

    task automatic send_bit(input logic b);
        wait_cyc(t_low / 2);
        sda_low_out <= ~b;
        wait_cyc(t_low / 2);
        scl_low_out <= 1'b0;
        wait_cyc(t_high);
        scl_low_out <= 1'b1;
    endtask

    // MSB first, then a released acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            send_bit(b[i]);
        end
        wait_cyc(t_low / 2);
        sda_low_out <= 1'b0;
        wait_cyc(t_low / 2);
        scl_low_out <= 1'b0;
        wait_cyc(t_high / 2);
        ack = ~sda_in;
        wait_cyc(t_high - t_high / 2);
        scl_low_out <= 1'b1;
    endtask
endmodule // tws_master_model

// [tws_hs_mode_switch_test.sv]
// Self-checking bench for the high-speed mode switch
`timescale 1ns/1ps
module tws_hs_mode_switch_test import tws_pkg::*;
;
    // Short lockup timer keeps the run brief
    localparam int TO_CYC = 200;
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl_low;
    logic sda_low;
    logic sda_drv;
    logic sda_oe;
    logic hs_mode;
    logic tmo;
    wire logic scl_wire;
    wire logic sda_wire;
    int n_fail = 0;
    int n_checks = 0;

    always #12.5 clk_in = ~clk_in;

    initial
    begin
        #3.7;
        forever #7.5 link_clk_in = ~link_clk_in;
    end

    // Pull-ups on both lines
    assign scl_wire = ~scl_low;
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_drv));

    tws_hs_mode_switch #(.TIMEOUT_CYCLES(TO_CYC)) tws_hs_mode_switch_inst
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .link_clk_in(link_clk_in),
        .scl_in(scl_wire),
        .sda_in(sda_wire),
        .sda_out(sda_drv),
        .sda_oe_out(sda_oe),
        .high_speed_mode_out(hs_mode),
        .timeout_out(tmo)
    );

    tws_master_model tws_master_model_inst
    (
        .clk_in(clk_in),
        .sda_in(sda_wire),
        .scl_low_out(scl_low),
        .sda_low_out(sda_low)
    );

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] b, input logic exp);
        logic ack;
        tws_master_model_inst.send_byte(b, ack);
        check_bit(ack, exp, "acknowledge");
    endtask

    task automatic hs_is(input logic exp);
        @(negedge clk_in);
        check_bit(hs_mode, exp, "mode");
    endtask

    task automatic test_reset();
        @(negedge clk_in);
        check_bit(hs_mode, 1'b0, "mode after reset");
        check_bit(sda_oe, 1'b0, "sda after reset");
        check_bit(tmo, 1'b0, "timeout after reset");
    endtask

    task automatic test_fs_write();
        tws_master_model_inst.start_cond();
        xfer(8'h80, 1'b1);
        xfer(8'h3C, 1'b1);
        hs_is(1'b0);
        tws_master_model_inst.restart();
        xfer(8'h82, 1'b0);
        tws_master_model_inst.restart();
        xfer(8'h81, 1'b0);
        tws_master_model_inst.stop_cond();
    endtask

    task automatic test_hs_entry(input logic [7:0] code);
        tws_master_model_inst.start_cond();
        xfer(code, 1'b0);
        hs_is(1'b1);
        // Without a restart the slave keeps ignoring the bus
        xfer(8'h80, 1'b0);
        tws_master_model_inst.set_speed(1'b1);
        tws_master_model_inst.restart();
        xfer(8'h80, 1'b1);
        xfer(8'hA5, 1'b1);
        tws_master_model_inst.restart();
        hs_is(1'b1);
        xfer(8'h80, 1'b1);
        tws_master_model_inst.stop_cond();
        tws_master_model_inst.set_speed(1'b0);
        repeat (10) @(posedge clk_in);
        hs_is(1'b0);
    endtask

    task automatic test_timeout();
        int n;
        n = 0;
        tws_master_model_inst.start_cond();
        xfer(8'h09, 1'b0);
        hs_is(1'b1);
        tws_master_model_inst.set_speed(1'b1);
        tws_master_model_inst.restart();
        // Own write address, then SCL held low inside the acknowledge slot
        for (int i = 7; i >= 0; i--)
        begin
            tws_master_model_inst.send_bit(i == 7);
        end
        repeat (4) @(negedge clk_in);
        check_bit(sda_oe, 1'b1, "sda before stall");
        while (tmo !== 1'b1 && n < 400)
        begin
            @(negedge clk_in);
            n++;
        end
        check_bit(n >= TO_CYC - 40 && n <= TO_CYC + 30, 1'b1, "timeout span");
        repeat (12) @(negedge clk_in);
        check_bit(hs_mode, 1'b0, "mode after timeout");
        check_bit(sda_oe, 1'b0, "sda after timeout");
        tws_master_model_inst.set_speed(1'b0);
        tws_master_model_inst.stop_cond();
        tws_master_model_inst.start_cond();
        xfer(8'h80, 1'b1);
        hs_is(1'b0);
        tws_master_model_inst.stop_cond();
    endtask

    // Reset while in high-speed mode, SCL still held low
    task automatic test_mid_reset();
        tws_master_model_inst.start_cond();
        xfer(8'h0A, 1'b0);
        hs_is(1'b1);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        check_bit(hs_mode, 1'b0, "mode in reset");
        check_bit(sda_oe, 1'b0, "sda in reset");
        @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        hs_is(1'b0);
        tws_master_model_inst.stop_cond();
        tws_master_model_inst.start_cond();
        xfer(8'h80, 1'b1);
        tws_master_model_inst.stop_cond();
    endtask

    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        test_reset();
        test_fs_write();
        test_hs_entry(8'h08);
        test_hs_entry(8'h0F);
        test_timeout();
        test_mid_reset();
        finish_test();
    end

    // Whole sequence needs about 10000 cycles
    initial
    begin
        repeat (40000) @(posedge clk_in);
        n_fail++;
        $display("wrong value at %0t: run did not complete", $time);
        finish_test();
    end
endmodule // tws_hs_mode_switch_test
